// ### hdl/mode_seq_defines.vh
// Purpose: Constants for the control-mode sequencer
// Assumes: 250 MHz core clock
// Notes: Values in 16-bit signed fixed point, output in 0.1 percent units
`ifndef MODE_SEQ_DEFINES_VH
`define MODE_SEQ_DEFINES_VH
// Register word offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_LSP 4'h2
`define REG_RATIO 4'h3
`define REG_BIAS 4'h4
`define REG_MANOUT 4'h5
`define REG_TARGET 4'h6
// Control register fields
`define CTRL_PV_TRACK 0
`define CTRL_RSP_TRACK 1
`define CTRL_AUTO_BIAS 2
`define CTRL_CURRENT_OUT 3
`define CTRL_CASCADE 4
`define CTRL_REMOTE_SEL 5
// Mode encodings
`define MODE_MAN_LOCAL 3'h0
`define MODE_AUTO_LOCAL 3'h1
`define MODE_MAN_REMOTE 3'h2
`define MODE_AUTO_REMOTE 3'h3
`define MODE_MAN_CASCADE 3'h4
`define MODE_AUTO_CASCADE 3'h5
// Output clamp limits, 0.1 percent units
`define OUT_MIN_TP 16'sh0000
`define OUT_MAX_TP 16'sh03e8
`define OUT_MIN_CUR 16'shffce
`define OUT_MAX_CUR 16'sh041a
`define OUT_STEP 16'sh0001
// Reset values
`define RATIO_RST 16'h0100
`define LSP_RST 16'h0000
// Commit delay
`define COMMIT_DELAY_S 15
`define CLK_HZ 250000000
`define COMMIT_CYCLES (`COMMIT_DELAY_S * `CLK_HZ)
`endif

// ### hdl/control_mode_sequencer.v
// Purpose: Control-mode sequencer with setpoint transfer actions
// Assumes: Keys are raw pins; process inputs are async and pass two flops
// Notes: Ratio is unsigned 8.8 fixed point; setpoints are signed 16-bit
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`include "mode_seq_defines.vh"

// Overview of operation
// - Commit setpoint after 15 s key quiet
// - Power-up restores last stored setpoint
// - Other key commits changed setpoint immediately
// - Auto local targets local setpoint
// - Auto remote target is ratio times remote plus bias
// - Manual output clamped by output type
// - Manual cascade holds both loops manual
// - Loop two pseudo-manual while loop one manual in manual cascade
// - Auto cascade feeds loop output as setpoint
// - Manual to auto local keeps stored setpoint
// - PV tracking copies PV in manual local and manual cascade
// - Remote entry uses stored ratio and bias
// - Auto bias equals local minus remote times ratio
// - RSP tracking loads remote into local
// - Without tracking local setpoint stays unchanged
// - Man/auto key toggles mode, indicator shown
module control_mode_sequencer #(
   parameter [31:0] COMMIT_CYCLES = `COMMIT_CYCLES
) (
   input wire i_core_clk,
   input wire i_rst,
   input wire [3:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   input wire i_key_man_auto,
   input wire i_key_inc,
   input wire i_key_dec,
   input wire i_key_other,
   input wire [15:0] i_process_variable,
   input wire [15:0] i_remote_setpoint,
   input wire [15:0] i_loop1_output,
   input wire [15:0] i_nv_local_setpoint,
   input wire i_nv_valid,
   output reg [15:0] o_nv_local_setpoint,
   output reg o_nv_write,
   output reg [15:0] o_loop1_target,
   output reg [15:0] o_loop2_target,
   output reg [15:0] o_output,
   output reg o_loop1_auto,
   output reg o_loop2_auto,
   output reg o_loop2_pseudo_manual,
   output reg o_out_from_loop2,
   output reg o_ind_auto,
   output reg o_ind_manual
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [3:0] key_s1_r, key_s2_r, key_s3_r;
reg [15:0] pv_s1_r, pv_s2_r, rsp_s1_r, rsp_s2_r, l1_s1_r, l1_s2_r;
always @(posedge i_core_clk or posedge i_rst) begin
   if (i_rst) begin
      key_s1_r <= 4'h0;
      key_s2_r <= 4'h0;
      key_s3_r <= 4'h0;
      pv_s1_r <= 16'h0000;
      pv_s2_r <= 16'h0000;
      rsp_s1_r <= 16'h0000;
      rsp_s2_r <= 16'h0000;
      l1_s1_r <= 16'h0000;
      l1_s2_r <= 16'h0000;
   end else begin
      key_s1_r <= {i_key_other, i_key_dec, i_key_inc, i_key_man_auto};
      key_s2_r <= key_s1_r;
      key_s3_r <= key_s2_r;
      pv_s1_r <= i_process_variable;
      pv_s2_r <= pv_s1_r;
      rsp_s1_r <= i_remote_setpoint;
      rsp_s2_r <= rsp_s1_r;
      l1_s1_r <= i_loop1_output;
      l1_s2_r <= l1_s1_r;
   end
end
// Edge detect after the second flop, so a held key acts once
wire [3:0] key_press = key_s2_r & ~key_s3_r;
wire press_ma = key_press[0];
wire press_inc = key_press[1];
wire press_dec = key_press[2];
wire press_other = key_press[3];

////////////////////////////////////////////////////////////////////////////////
// Registers and state
reg [5:0] ctrl_r;
reg [2:0] mode_r, mode_nxt;
reg [15:0] lsp_r, lsp_nxt;
reg [15:0] ratio_r;
reg [15:0] bias_r, bias_nxt;
reg [15:0] manout_r, manout_nxt;
reg [15:0] stored_lsp_r;
reg dirty_r;
// A 15 s quiet period at this clock needs all 32 counter bits
reg [31:0] quiet_cnt_r;
reg restore_r;

wire remote_mode = (mode_r == `MODE_MAN_REMOTE) || (mode_r == `MODE_AUTO_REMOTE);
wire manual_mode = (mode_r == `MODE_MAN_LOCAL) || (mode_r == `MODE_MAN_REMOTE)
   || (mode_r == `MODE_MAN_CASCADE);

// Ratio times remote, 8.8 scaling, kept to 16 bits
wire signed [32:0] rsp_prod = $signed(rsp_s2_r) * $signed({1'b0, ratio_r});
wire [15:0] rsp_scaled = rsp_prod[23:8];
wire [15:0] remote_target = rsp_scaled + bias_r;

wire signed [15:0] out_min = ctrl_r[`CTRL_CURRENT_OUT] ? `OUT_MIN_CUR : `OUT_MIN_TP;
wire signed [15:0] out_max = ctrl_r[`CTRL_CURRENT_OUT] ? `OUT_MAX_CUR : `OUT_MAX_TP;
wire signed [16:0] out_up = $signed(manout_r) + $signed(`OUT_STEP);
wire signed [16:0] out_dn = $signed(manout_r) - $signed(`OUT_STEP);

wire bus_wr = i_avs_write && !o_avs_waitrequest;
// Read data is captured as the request is taken, so it stands while waitrequest is low
wire bus_rd = i_avs_read && o_avs_waitrequest;
wire wr_lsp = bus_wr && (i_avs_address == `REG_LSP);

////////////////////////////////////////////////////////////////////////////////
// Mode transitions and transfer actions, all in one cycle
always @* begin
   mode_nxt = mode_r;
   lsp_nxt = lsp_r;
   bias_nxt = bias_r;
   manout_nxt = manout_r;
   if (press_ma) begin
      case (mode_r)
         `MODE_MAN_LOCAL: mode_nxt = `MODE_AUTO_LOCAL;
         `MODE_AUTO_LOCAL: mode_nxt = `MODE_MAN_LOCAL;
         `MODE_MAN_REMOTE: mode_nxt = `MODE_AUTO_REMOTE;
         `MODE_AUTO_REMOTE: mode_nxt = `MODE_MAN_REMOTE;
         `MODE_MAN_CASCADE: mode_nxt = `MODE_AUTO_CASCADE;
         `MODE_AUTO_CASCADE: mode_nxt = `MODE_MAN_CASCADE;
         default: mode_nxt = `MODE_MAN_LOCAL;
      endcase
   end else if (bus_wr && (i_avs_address == `REG_CTRL) && i_avs_byteenable[0]) begin
      // Setpoint source and cascade selection keep the manual/auto half
      if (i_avs_writedata[`CTRL_CASCADE])
         mode_nxt = manual_mode ? `MODE_MAN_CASCADE : `MODE_AUTO_CASCADE;
      else if (i_avs_writedata[`CTRL_REMOTE_SEL])
         mode_nxt = manual_mode ? `MODE_MAN_REMOTE : `MODE_AUTO_REMOTE;
      else
         mode_nxt = manual_mode ? `MODE_MAN_LOCAL : `MODE_AUTO_LOCAL;
   end
   // Entering auto remote from auto local, auto cascade or manual remote
   if (mode_nxt == `MODE_AUTO_REMOTE && mode_r != `MODE_AUTO_REMOTE) begin
      if (ctrl_r[`CTRL_AUTO_BIAS])
         bias_nxt = lsp_r - rsp_scaled;
      // Otherwise the stored bias is kept
   end
   // Leaving remote operation
   if (remote_mode && (mode_nxt != `MODE_MAN_REMOTE) && (mode_nxt != `MODE_AUTO_REMOTE)) begin
      if (ctrl_r[`CTRL_RSP_TRACK])
         lsp_nxt = rsp_s2_r;
      // Otherwise lsp is left alone
   end
   // No tracking in remote modes, where the remote input owns the target
   if (manual_mode && ctrl_r[`CTRL_PV_TRACK] && !remote_mode)
      lsp_nxt = pv_s2_r;
   if (wr_lsp && !manual_mode)
      lsp_nxt = i_avs_writedata[15:0];
   if (manual_mode) begin
      if (press_inc)
         manout_nxt = (out_up > out_max) ? out_max : out_up[15:0];
      else if (press_dec)
         manout_nxt = (out_dn < out_min) ? out_min : out_dn[15:0];
      // Clamp again so a change of output type pulls a stale value into range
      if ($signed(manout_nxt) > out_max)
         manout_nxt = out_max;
      else if ($signed(manout_nxt) < out_min)
         manout_nxt = out_min;
   end
end

always @(posedge i_core_clk or posedge i_rst) begin
   if (i_rst) begin
      mode_r <= `MODE_MAN_LOCAL;
      lsp_r <= `LSP_RST;
      bias_r <= 16'h0000;
      manout_r <= 16'h0000;
      ratio_r <= `RATIO_RST;
      ctrl_r <= 6'h00;
      restore_r <= 1'b1;
   end else begin
      mode_r <= mode_nxt;
      bias_r <= bias_nxt;
      manout_r <= manout_nxt;
      if (restore_r) begin
         // Non-volatile copy wins once after power-up
         lsp_r <= i_nv_valid ? i_nv_local_setpoint : lsp_nxt;
         restore_r <= 1'b0;
      end else begin
         lsp_r <= lsp_nxt;
      end
      // Writes take effect in the cycle waitrequest is low
      if (bus_wr && i_avs_byteenable[0]) begin
         case (i_avs_address)
            `REG_CTRL: ctrl_r <= i_avs_writedata[5:0];
            `REG_RATIO: ratio_r <= i_avs_writedata[15:0];
            default: ;
         endcase
      end
      // A bias write wins over a transfer action in the same cycle
      if (bus_wr && (i_avs_address == `REG_BIAS))
         bias_r <= i_avs_writedata[15:0];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Deferred non-volatile commit
// A changed setpoint goes out after a quiet period, or at once on a key
always @(posedge i_core_clk or posedge i_rst) begin
   if (i_rst) begin
      dirty_r <= 1'b0;
      quiet_cnt_r <= 32'h0;
      stored_lsp_r <= `LSP_RST;
      o_nv_write <= 1'b0;
      o_nv_local_setpoint <= 16'h0000;
   end else begin
      o_nv_write <= 1'b0;
      // The stored copy follows the power-up restore, so the first commit compares right
      if (restore_r) begin
         stored_lsp_r <= i_nv_valid ? i_nv_local_setpoint : `LSP_RST;
      end else if (wr_lsp && !manual_mode) begin
         dirty_r <= 1'b1;
         quiet_cnt_r <= 32'h0;
      end else if (dirty_r) begin
         if ((|key_press) || quiet_cnt_r >= COMMIT_CYCLES - 32'h1) begin
            dirty_r <= 1'b0;
            // An unchanged value is not rewritten, to spare the storage wear
            if (lsp_r != stored_lsp_r) begin
               o_nv_write <= 1'b1;
               o_nv_local_setpoint <= lsp_r;
               stored_lsp_r <= lsp_r;
            end
         end else begin
            quiet_cnt_r <= quiet_cnt_r + 32'h1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Loop targets and output routing
always @(posedge i_core_clk or posedge i_rst) begin
   if (i_rst) begin
      o_loop1_target <= 16'h0000;
      o_loop2_target <= 16'h0000;
      o_output <= 16'h0000;
      o_loop1_auto <= 1'b0;
      o_loop2_auto <= 1'b0;
      o_loop2_pseudo_manual <= 1'b0;
      o_out_from_loop2 <= 1'b0;
      o_ind_auto <= 1'b0;
      o_ind_manual <= 1'b1;
   end else begin
      o_loop1_target <= (mode_r == `MODE_AUTO_REMOTE) ? remote_target : lsp_r;
      // Loop one output sets loop two target in auto cascade
      o_loop2_target <= (mode_r == `MODE_AUTO_CASCADE) ? l1_s2_r : lsp_r;
      o_output <= manout_r;
      o_loop1_auto <= !manual_mode;
      o_loop2_auto <= (mode_r == `MODE_AUTO_CASCADE);
      o_loop2_pseudo_manual <= (mode_r == `MODE_MAN_CASCADE) && ctrl_r[`CTRL_CASCADE];
      o_out_from_loop2 <= (mode_r == `MODE_AUTO_CASCADE) || (mode_r == `MODE_MAN_CASCADE);
      // Indicators are registered with the mode, so they never disagree
      o_ind_auto <= !manual_mode;
      o_ind_manual <= manual_mode;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon slave: one wait cycle per access
always @(posedge i_core_clk or posedge i_rst) begin
   if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
   end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (bus_rd) begin
         case (i_avs_address)
            `REG_CTRL: o_avs_readdata <= {26'h0, ctrl_r};
            `REG_STATUS: o_avs_readdata <= {28'h0, dirty_r, mode_r};
            `REG_LSP: o_avs_readdata <= {16'h0, lsp_r};
            `REG_RATIO: o_avs_readdata <= {16'h0, ratio_r};
            `REG_BIAS: o_avs_readdata <= {16'h0, bias_r};
            `REG_MANOUT: o_avs_readdata <= {16'h0, manout_r};
            `REG_TARGET: o_avs_readdata <= {16'h0, o_loop1_target};
            default: o_avs_readdata <= 32'h0;
         endcase
      end
   end
end

endmodule

// ### verif/front_panel.sv
// Purpose: Operator keys and measured inputs facing the sequencer
// Assumes: A press request is a one-cycle pulse from the bench
// Notes: HOLD sets how long a key stays down, prompt or slow operator
`timescale 1ns/1ns
module front_panel #(
   parameter [3:0] HOLD = 4'h6,
   parameter [15:0] PV = 16'h0444,
   parameter [15:0] RSP = 16'h0010,
   parameter [15:0] L1OUT = 16'h0777
) (
   input wire i_core_clk,
   input wire [3:0] i_press,
   output reg [3:0] o_keys,
   output wire [15:0] o_process_variable,
   output wire [15:0] o_remote_setpoint,
   output wire [15:0] o_loop1_output
);
   reg [3:0] cnt_r;
   assign o_process_variable = PV;
   assign o_remote_setpoint = RSP;
   assign o_loop1_output = L1OUT;
   initial begin
      o_keys = 4'h0;
      cnt_r = 4'h0;
   end
   // Key stays down for HOLD+1 cycles so the synchroniser sees a clean press
   always @(posedge i_core_clk) begin
      if (i_press != 4'h0) begin
         o_keys <= i_press;
         cnt_r <= HOLD;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end else begin
         o_keys <= 4'h0;
      end
   end
endmodule

// ### verif/mode_seq_sva.sv
// Purpose: Port checks for the control-mode sequencer
// Assumes: One clock, async active-high reset
// Notes: Bound into every sequencer instance
`timescale 1ns/1ns
module mode_seq_sva #(
   parameter [31:0] COMMIT_CYCLES = 32'd50
) (
   input wire i_core_clk,
   input wire i_rst,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire o_avs_waitrequest,
   input wire i_key_man_auto,
   input wire o_nv_write,
   input wire [15:0] o_output,
   input wire o_loop1_auto,
   input wire o_loop2_auto,
   input wire o_loop2_pseudo_manual,
   input wire o_ind_auto,
   input wire o_ind_manual
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence bus_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence key_rise;
      $rose(i_key_man_auto);
   endsequence
   a_bus_answer: assert property (bus_req |=> !o_avs_waitrequest)
      else $error("bus request not answered");
   a_wait_pulse: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_cause: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
      else $error("answer without request");
   a_nv_pulse: assert property (o_nv_write |=> !o_nv_write)
      else $error("commit pulse too long");
   a_ind_excl: assert property (o_ind_auto != o_ind_manual)
      else $error("indicators disagree");
   a_mode_toggle: assert property (key_rise |-> ##[2:5] $changed(o_ind_auto))
      else $error("mode did not toggle");
   a_out_clamp: assert property ($signed(o_output) >= -50 && $signed(o_output) <= 1050)
      else $error("manual output out of range");
   a_man_loops: assert property (o_ind_manual |-> !o_loop1_auto && !o_loop2_auto)
      else $error("loop auto in manual");
   a_pseudo_man: assert property (o_loop2_pseudo_manual |-> !o_loop1_auto)
      else $error("pseudo-manual with loop one auto");
endmodule
bind control_mode_sequencer mode_seq_sva #(.COMMIT_CYCLES(COMMIT_CYCLES)) u_sva (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
   .i_key_man_auto(i_key_man_auto), .o_nv_write(o_nv_write), .o_output(o_output),
   .o_loop1_auto(o_loop1_auto), .o_loop2_auto(o_loop2_auto),
   .o_loop2_pseudo_manual(o_loop2_pseudo_manual), .o_ind_auto(o_ind_auto),
   .o_ind_manual(o_ind_manual));

// ### verif/control_mode_sequencer_tb.sv
// Purpose: Self-checking bench for the control-mode sequencer
// Assumes: Commit delay shortened to 50 cycles
// Notes: Registers reached over Avalon-MM with waitrequest
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value %0t got %h exp %h", $time, a, e); end end
module control_mode_sequencer_tb;
   reg clk, rst, rd, wr;
   reg [3:0] adr, press, be;
   reg [31:0] wd, q;
   reg [15:0] nvv;
   wire [31:0] rdat;
   wire [3:0] keys;
   wire wt, nvw, l1a, l2a, pm, ofl, ia, im;
   wire [15:0] pv, rsp, l1o, nvo, t1, t2, outv;
   integer miscompares = 0, n_checks = 0, nvc = 0, cyc = 0, i;
   front_panel fp (.i_core_clk(clk), .i_press(press), .o_keys(keys),
      .o_process_variable(pv), .o_remote_setpoint(rsp), .o_loop1_output(l1o));
   control_mode_sequencer #(.COMMIT_CYCLES(50)) dut (.i_core_clk(clk), .i_rst(rst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
      .i_key_man_auto(keys[0]), .i_key_inc(keys[1]), .i_key_dec(keys[2]),
      .i_key_other(keys[3]), .i_process_variable(pv), .i_remote_setpoint(rsp),
      .i_loop1_output(l1o), .i_nv_local_setpoint(16'h0123), .i_nv_valid(1'b1),
      .o_nv_local_setpoint(nvo), .o_nv_write(nvw), .o_loop1_target(t1),
      .o_loop2_target(t2), .o_output(outv), .o_loop1_auto(l1a), .o_loop2_auto(l2a),
      .o_loop2_pseudo_manual(pm), .o_out_from_loop2(ofl), .o_ind_auto(ia),
      .o_ind_manual(im));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // Cycle ceiling well above the roughly 1240 cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (nvw === 1'b1) begin
         nvc <= nvc + 1;
         nvv <= nvo;
      end
      if (cyc == 5000) begin
         miscompares++;
         end_sim;
      end
   end
   task bus(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         rd <= !w;
         wr <= w;
         adr <= a;
         wd <= d;
         @(posedge clk);
         while (wt !== 1'b0) @(posedge clk);
         q = rdat;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task rdc(input [3:0] a, input [15:0] e);
      begin
         bus(1'b0, a, 32'h0);
         `CHK(q[15:0], e)
      end
   endtask
   task key(input [1:0] k, input integer n);
      integer j;
      begin
         for (j = 0; j < n; j++) begin
            @(posedge clk);
            press <= 4'h1 << k;
            @(posedge clk);
            press <= 4'h0;
            repeat (14) @(posedge clk);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      wd = 32'h0;
      press = 4'h0;
      be = 4'hf;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rdc(4'h2, 16'h0123);
      rdc(4'h3, 16'h0100);
      rdc(4'h1, 16'h0000);
      rdc(4'h7, 16'h0000);
      key(2, 2);
      `CHK(outv, 16'h0000)
      key(1, 3);
      `CHK(outv, 16'h0003)
      bus(1'b1, 4'h0, 32'h8);
      key(2, 55);
      `CHK(outv, 16'hffce)
      `CHK(im, 1'b1)
      key(0, 1);
      `CHK({ia, im, l1a}, 3'b101)
      rdc(4'h1, 16'h0001);
      `CHK(t1, 16'h0123)
      bus(1'b1, 4'h2, 32'h0200);
      i = nvc;
      repeat (4) @(posedge clk);
      `CHK(t1, 16'h0200)
      repeat (40) @(posedge clk);
      `CHK(nvc, i)
      repeat (30) @(posedge clk);
      `CHK(nvc, i + 1)
      `CHK(nvv, 16'h0200)
      bus(1'b1, 4'h2, 32'h0300);
      i = nvc;
      key(3, 1);
      `CHK(nvc, i + 1)
      `CHK(nvv, 16'h0300)
      bus(1'b1, 4'h3, 32'h0200);
      bus(1'b1, 4'h4, 32'h0005);
      bus(1'b1, 4'h0, 32'h20);
      repeat (4) @(posedge clk);
      rdc(4'h1, 16'h0003);
      `CHK(t1, 16'h0025)
      bus(1'b1, 4'h0, 32'h0);
      rdc(4'h2, 16'h0300);
      bus(1'b1, 4'h0, 32'h4);
      bus(1'b1, 4'h0, 32'h24);
      repeat (4) @(posedge clk);
      rdc(4'h4, 16'h02e0);
      `CHK(t1, 16'h0300)
      key(0, 1);
      rdc(4'h1, 16'h0002);
      bus(1'b1, 4'h0, 32'h26);
      bus(1'b1, 4'h4, 32'h0);
      key(0, 1);
      rdc(4'h4, 16'h02e0);
      bus(1'b1, 4'h0, 32'h10);
      repeat (4) @(posedge clk);
      rdc(4'h1, 16'h0005);
      `CHK({ofl, t2}, {1'b1, 16'h0777})
      rdc(4'h2, 16'h0010);
      key(0, 1);
      rdc(4'h1, 16'h0004);
      `CHK({l1a, l2a, ofl}, 3'b001)
      `CHK(pm, 1'b1)
      bus(1'b1, 4'h0, 32'h1);
      repeat (4) @(posedge clk);
      rdc(4'h2, 16'h0444);
      key(0, 1);
      `CHK(t1, 16'h0444)
      end_sim;
   end
endmodule
